// ===== cmam_cfg.svh
/*
  Constants of the core memory map block: core register offsets, bank
  partitioning, vectors, pointer space and stack size.
  Assumes it is included by bare name ahead of the package and the design.
*/
`ifndef CMAM_CFG_SVH
`define CMAM_CFG_SVH

// ----------------------------------------------------------------
// Core register offsets within every bank
// ----------------------------------------------------------------
`define CMAM_OFS_INDIRECT_PORT_0  7'h00
`define CMAM_OFS_INDIRECT_PORT_1  7'h01
`define CMAM_OFS_PC_LOW           7'h02
`define CMAM_OFS_CPU_FLAGS        7'h03
`define CMAM_OFS_PTR0_LOW         7'h04
`define CMAM_OFS_PTR0_HIGH        7'h05
`define CMAM_OFS_PTR1_LOW         7'h06
`define CMAM_OFS_PTR1_HIGH        7'h07
`define CMAM_OFS_BANK_SELECT      7'h08
`define CMAM_OFS_WORKING          7'h09
`define CMAM_OFS_PC_LATCH_HIGH    7'h0a
`define CMAM_OFS_INT_CONTROL      7'h0b

// ----------------------------------------------------------------
// Bank partitioning
// ----------------------------------------------------------------
`define CMAM_PERIPH_FIRST         7'h0c
`define CMAM_GPR_FIRST            7'h20
`define CMAM_COMMON_FIRST         7'h70
`define CMAM_GPR_BYTES            13'h0050
`define CMAM_BANK_COUNT           32

// ----------------------------------------------------------------
// Program space, vectors, high endurance region
// ----------------------------------------------------------------
`define CMAM_RESET_VECTOR         15'h0000
`define CMAM_INT_VECTOR           15'h0004
`define CMAM_HEF_WORDS            15'h0080

// ----------------------------------------------------------------
// Pointer space, stack and CPU flags
// ----------------------------------------------------------------
`define CMAM_PTR_PROG_BIT         15
`define CMAM_LINEAR_TAG           3'h1
`define CMAM_STACK_DEPTH          16
`define CMAM_STACK_FULL           5'h10
`define CMAM_FLAGS_RESET          5'h18
`define CMAM_FLAGS_WR_MASK        5'h07

`endif

// ===== cmam_core.sv
/*
  Core memory map: program counter and vectors, return stack, two
  indirect pointers, core register window and banked data addressing.
  Assumes a program flash that answers a held address from the next cycle,
  and a data RAM that answers one cycle after a read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmam_cfg.svh"

module cmam_core
  import cmam_pkg::*;
#(
  parameter int PROG_WORDS = 1024,  // Implemented program words
  parameter int GPR_BANKS  = 2      // Banks that hold general RAM
) (
  input  wire logic        clk_i,                  // 200 MHz core clock
  input  wire logic        srst_i,                 // Synchronous reset, high
  input  wire logic        fetch_i,                // Advance program counter
  input  wire logic        call_i,                 // Push and jump
  input  wire logic        ret_i,                  // Pop into counter
  input  wire logic        irq_i,                  // Interrupt entry
  input  wire logic        retfie_i,               // Interrupt return
  input  wire logic [14:0] target_i,               // Call target
  input  wire logic        stack_reset_en_i,       // Stack fault reset enable
  input  wire logic [1:0]  stack_flag_clr_i,       // Clear {underflow, overflow}
  input  wire logic        file_rd_i,              // File register read
  input  wire logic        file_wr_i,              // File register write
  input  wire logic [6:0]  file_addr_i,            // Offset within bank
  input  wire logic [7:0]  file_wdata_i,           // Write data
  output logic             rd_valid_o,             // Read data valid pulse
  output logic [7:0]       rd_data_o,              // Read data
  output logic             busy_o,                 // Read in progress
  output logic [14:0]      pc_o,                   // Program counter
  output logic [14:0]      pfm_addr_o,             // Program flash address
  output logic             pfm_rd_o,               // Data read from flash
  input  wire logic [13:0] pfm_data_i,             // Program flash word
  output logic             hef_region_o,           // Address in endurance area
  output logic [11:0]      ram_addr_o,             // Banked data address
  output logic             ram_re_o,               // RAM read strobe
  output logic             ram_we_o,               // RAM write strobe
  output logic [7:0]       ram_wdata_o,            // RAM write data
  input  wire logic [7:0]  ram_rdata_i,            // RAM read data
  output logic             stack_overflow_flag_o,  // Sticky overflow
  output logic             stack_underflow_flag_o, // Sticky underflow
  output logic             soft_reset_o            // Software reset request
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PROG_WORDS < 256 || PROG_WORDS > 32768 || (PROG_WORDS & (PROG_WORDS - 1)) != 0) begin : g_bad_prog
    $error("PROG_WORDS must be a power of two from 256 to 32768");
  end
  if (GPR_BANKS < 1 || GPR_BANKS > `CMAM_BANK_COUNT) begin : g_bad_gpr
    $error("GPR_BANKS must be 1 to 32");
  end

  localparam logic [14:0] PC_MASK  = 15'(PROG_WORDS - 1);
  localparam logic [14:0] HEF_BASE = 15'(PROG_WORDS) - `CMAM_HEF_WORDS;
  localparam logic [12:0] LIN_SIZE = 13'(GPR_BANKS) * `CMAM_GPR_BYTES;

  cmam_regs_s q;
  cmam_regs_s d;

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------
  // bank and offset split
  function automatic cmam_dref_s data_ref(input logic [11:0] a);
    cmam_dref_s r;
    r.hit  = 1'b1;
    r.core = 1'b0;
    r.addr = a;
    if (a[6:0] < `CMAM_PERIPH_FIRST) begin
      r.core = 1'b1;
    end else if (a[6:0] >= `CMAM_COMMON_FIRST) begin
      r.addr = {5'h00, a[6:0]};
    end else if (a[6:0] >= `CMAM_GPR_FIRST && 32'(a[11:7]) >= GPR_BANKS) begin
      r.hit = 1'b0;
    end
    return r;
  endfunction

  // linear index to banked general RAM
  function automatic logic [11:0] lin_map(input logic [12:0] l);
    logic [12:0] rem;
    logic [4:0]  bank;
    rem  = l;
    bank = 5'h00;
    for (int i = 0; i < `CMAM_BANK_COUNT - 1; i++) begin
      if (rem >= `CMAM_GPR_BYTES) begin
        rem  = rem - `CMAM_GPR_BYTES;
        bank = bank + 5'h01;
      end
    end
    return {bank, `CMAM_GPR_FIRST + rem[6:0]};
  endfunction

  // one pointer space for data and program
  // top bit clear selects data memory
  function automatic cmam_dref_s ptr_ref(input logic [15:0] p);
    cmam_dref_s r;
    r = '0;
    if (p[15:12] == 4'h0) begin
      r = data_ref(p[11:0]);
    end else if (p[15:13] == `CMAM_LINEAR_TAG && p[12:0] < LIN_SIZE) begin
      r.hit  = 1'b1;
      r.addr = lin_map(p[12:0]);
    end
    return r;
  endfunction

  function automatic logic [7:0] core_rd(input logic [6:0] off, input cmam_regs_s s);
    logic [7:0] v;
    v = 8'h00;
    unique case (off)
      `CMAM_OFS_PC_LOW:        v = s.pc[7:0];
      `CMAM_OFS_CPU_FLAGS:     v = {3'h0, s.flags};
      `CMAM_OFS_PTR0_LOW:      v = s.ptr0[7:0];
      `CMAM_OFS_PTR0_HIGH:     v = s.ptr0[15:8];
      `CMAM_OFS_PTR1_LOW:      v = s.ptr1[7:0];
      `CMAM_OFS_PTR1_HIGH:     v = s.ptr1[15:8];
      `CMAM_OFS_BANK_SELECT:   v = {3'h0, s.bank_select};
      `CMAM_OFS_WORKING:       v = s.working_register;
      `CMAM_OFS_PC_LATCH_HIGH: v = {1'b0, s.latch_high};
      `CMAM_OFS_INT_CONTROL:   v = s.interrupt_control;
      default:                 v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        take_rd;
    logic        take_wr;
    logic        indirect;
    logic [15:0] ptr;
    cmam_dref_s  ref_d;
    logic        core_wr;
    logic [6:0]  core_off;
    logic        push;
    logic        pop;
    take_rd  = 1'b0;
    take_wr  = 1'b0;
    indirect = 1'b0;
    ptr      = 16'h0000;
    ref_d    = '0;
    core_wr  = 1'b0;
    core_off = 7'h00;
    push     = 1'b0;
    pop      = 1'b0;
    d          = q;
    d.ram_re   = 1'b0;
    d.ram_we   = 1'b0;
    d.rd_valid = 1'b0;
    d.soft_rst = 1'b0;

    // Reads are refused while one is in flight; a write is dropped only when a read is taken
    take_rd  = file_rd_i && (q.st == CMAM_IDLE);
    take_wr  = file_wr_i && !take_rd;
    indirect = file_addr_i == `CMAM_OFS_INDIRECT_PORT_0 || file_addr_i == `CMAM_OFS_INDIRECT_PORT_1;
    ptr      = file_addr_i[0] ? q.ptr1 : q.ptr0;
    // direct access banked by bank select
    ref_d    = indirect ? ptr_ref(ptr) : data_ref({q.bank_select, file_addr_i});

    unique case (q.st)
      CMAM_IDLE: begin
        if (take_rd) begin
          // top bit steers to program memory
          if (indirect && ptr[`CMAM_PTR_PROG_BIT]) begin
            d.pfm_addr = ptr[14:0] & PC_MASK;
            d.pfm_rd   = 1'b1;
            d.st       = CMAM_PFM_WAIT;
          end else if (!ref_d.hit) begin
            d.rd_valid = 1'b1;
            d.rd_data  = 8'h00;
          end else if (ref_d.core) begin
            d.rd_valid = 1'b1;
            d.rd_data  = (indirect && ref_d.addr[6:1] == 6'h00) ? 8'h00 : core_rd(ref_d.addr[6:0], q);
          end else begin
            d.ram_addr = ref_d.addr;
            d.ram_re   = 1'b1;
            d.st       = CMAM_RAM_WAIT;
          end
        end
      end
      CMAM_RAM_WAIT: d.st = CMAM_RAM_CAP;
      CMAM_RAM_CAP: begin
        d.rd_valid = 1'b1;
        d.rd_data  = ram_rdata_i;
        d.st       = CMAM_IDLE;
      end
      CMAM_PFM_WAIT: d.st = CMAM_PFM_XTRA;
      CMAM_PFM_XTRA: d.st = CMAM_PFM_CAP;
      CMAM_PFM_CAP: begin
        // low byte of the word only
        d.rd_valid = 1'b1;
        d.rd_data  = pfm_data_i[7:0];
        d.pfm_rd   = 1'b0;
        d.st       = CMAM_IDLE;
      end
      default: d.st = CMAM_IDLE;
    endcase

    if (take_wr) begin
      if (indirect && ptr[`CMAM_PTR_PROG_BIT]) begin
        core_wr = 1'b0;
      end else if (ref_d.hit && ref_d.core) begin
        core_wr  = !(indirect && ref_d.addr[6:1] == 6'h00);
        core_off = ref_d.addr[6:0];
      end else if (ref_d.hit) begin
        d.ram_addr  = ref_d.addr;
        d.ram_wdata = file_wdata_i;
        d.ram_we    = 1'b1;
      end
    end

    if (core_wr) begin
      unique case (core_off)
        `CMAM_OFS_PC_LOW:        d.pc = {q.latch_high, file_wdata_i} & PC_MASK;
        `CMAM_OFS_CPU_FLAGS:     d.flags = (q.flags & ~`CMAM_FLAGS_WR_MASK) |
                                           (file_wdata_i[4:0] & `CMAM_FLAGS_WR_MASK);
        `CMAM_OFS_PTR0_LOW:      d.ptr0[7:0] = file_wdata_i;
        `CMAM_OFS_PTR0_HIGH:     d.ptr0[15:8] = file_wdata_i;
        `CMAM_OFS_PTR1_LOW:      d.ptr1[7:0] = file_wdata_i;
        `CMAM_OFS_PTR1_HIGH:     d.ptr1[15:8] = file_wdata_i;
        `CMAM_OFS_BANK_SELECT:   d.bank_select = file_wdata_i[4:0];
        `CMAM_OFS_WORKING:       d.working_register = file_wdata_i;
        `CMAM_OFS_PC_LATCH_HIGH: d.latch_high = file_wdata_i[6:0];
        `CMAM_OFS_INT_CONTROL:   d.interrupt_control = file_wdata_i;
        default:                 d.working_register = d.working_register;
      endcase
    end

    // ----------------------------------------------------------------
    // Program flow; control beats a same-cycle counter write, except a pop that underflows
    // ----------------------------------------------------------------
    push = irq_i || (call_i && !retfie_i);
    pop  = !irq_i && (retfie_i || (!call_i && ret_i));
    if (irq_i) begin
      d.pc = `CMAM_INT_VECTOR;
      d.sh_working_register  = q.working_register;
      d.sh_flags = q.flags;
      d.sh_bsr   = q.bank_select;
      d.sh_latch = q.latch_high;
      d.sh_ptr0  = q.ptr0;
      d.sh_ptr1  = q.ptr1;
    end else if (call_i) begin
      d.pc = target_i & PC_MASK;
    end else if (fetch_i && !pop) begin
      d.pc = (q.pc + 15'h0001) & PC_MASK;
    end

    if (push) begin
      if (q.sp == `CMAM_STACK_FULL) begin
        d.ovf      = 1'b1;
        d.soft_rst = stack_reset_en_i;
      end else begin
        d.stack[q.sp[3:0]] = q.pc;
        d.sp               = q.sp + 5'h01;
      end
    end else if (pop) begin
      if (q.sp == 5'h00) begin
        d.unf      = 1'b1;
        d.soft_rst = stack_reset_en_i;
      end else begin
        d.pc = q.stack[q.sp[3:0] - 4'h1] & PC_MASK;
        d.sp = q.sp - 5'h01;
      end
      if (retfie_i) begin
        d.working_register       = q.sh_working_register;
        d.flags      = q.sh_flags;
        d.bank_select        = q.sh_bsr;
        d.latch_high = q.sh_latch;
        d.ptr0       = q.sh_ptr0;
        d.ptr1       = q.sh_ptr1;
      end
    end

    // Set wins over a same-cycle clear
    if (stack_flag_clr_i[0] && !(push && q.sp == `CMAM_STACK_FULL)) begin
      d.ovf = 1'b0;
    end
    if (stack_flag_clr_i[1] && !(pop && q.sp == 5'h00)) begin
      d.unf = 1'b0;
    end

    // Flash follows the counter unless a data read holds it
    if (d.st == CMAM_IDLE) begin
      d.pfm_addr = d.pc;
    end
    d.hef  = d.pfm_addr >= HEF_BASE;
    d.busy = d.st != CMAM_IDLE;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q          <= '0;
      q.st       <= CMAM_IDLE;
      q.pc       <= `CMAM_RESET_VECTOR;
      q.pfm_addr <= `CMAM_RESET_VECTOR;
      q.flags    <= `CMAM_FLAGS_RESET;
    end else begin
      q <= d;
    end
  end

  assign rd_valid_o             = q.rd_valid;
  assign rd_data_o              = q.rd_data;
  assign busy_o                 = q.busy;
  assign pc_o                   = q.pc;
  assign pfm_addr_o             = q.pfm_addr;
  assign pfm_rd_o               = q.pfm_rd;
  assign hef_region_o           = q.hef;
  assign ram_addr_o             = q.ram_addr;
  assign ram_re_o               = q.ram_re;
  assign ram_we_o               = q.ram_we;
  assign ram_wdata_o            = q.ram_wdata;
  assign stack_overflow_flag_o  = q.ovf;
  assign stack_underflow_flag_o = q.unf;
  assign soft_reset_o           = q.soft_rst;

endmodule
`default_nettype wire

// ===== cmam_core_properties.sv
/*
  Port checker of the core memory map block.
  Assumes a bind to cmam_core; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cmam_core_properties
  import cmam_pkg::*;
#(
  parameter int PROG_WORDS = 1024 // Implemented program words
) (
  input wire logic        clk_i,                  // Clock
  input wire logic        srst_i,                 // Reset
  input wire logic        fetch_i,                // Fetch
  input wire logic        call_i,                 // Call
  input wire logic        ret_i,                  // Return
  input wire logic        irq_i,                  // Interrupt
  input wire logic        retfie_i,               // Interrupt return
  input wire logic        file_wr_i,              // Write
  input wire logic        file_rd_i,              // Read
  input wire logic [6:0]  file_addr_i,            // Offset
  input wire logic [1:0]  stack_flag_clr_i,       // Flag clear
  input wire logic        busy_o,                 // Busy
  input wire logic        rd_valid_o,             // Read valid
  input wire logic [7:0]  rd_data_o,              // Read data
  input wire logic [14:0] pc_o,                   // Counter
  input wire logic [14:0] pfm_addr_o,             // Flash address
  input wire logic        pfm_rd_o,               // Flash data read
  input wire logic [13:0] pfm_data_i,             // Flash word
  input wire logic        hef_region_o,           // Endurance area
  input wire logic        ram_re_o,               // RAM read
  input wire logic [7:0]  ram_rdata_i,            // RAM data
  input wire logic        stack_overflow_flag_o,  // Overflow
  input wire logic        stack_underflow_flag_o, // Underflow
  input wire logic        soft_reset_o            // Soft reset
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence ram_seq;
    busy_o ##1 busy_o ##1 (rd_valid_o && !busy_o && rd_data_o == $past(ram_rdata_i));
  endsequence
  sequence pfm_seq;
    busy_o [*3] ##1 (rd_valid_o && !pfm_rd_o && rd_data_o == $past(pfm_data_i[7:0]));
  endsequence
  reset_vector_a: assert property (disable iff (1'b0) srst_i |=> pc_o == 15'h0000)
    else $error("counter not at zero after reset");
  irq_vector_a: assert property (irq_i |=> pc_o == 15'h0004)
    else $error("interrupt did not vector to four");
  pc_wrap_a: assert property (fetch_i && !(call_i || ret_i || irq_i || retfie_i || file_wr_i)
    |=> pc_o == 15'(($past(pc_o) + 1) % PROG_WORDS)) else $error("counter step or wrap wrong");
  hef_region_a: assert property (hef_region_o == (pfm_addr_o >= 15'(PROG_WORDS - 128)))
    else $error("endurance region flag wrong");
  ram_answer_a: assert property (ram_re_o |-> ram_seq)
    else $error("data read answer wrong");
  pfm_answer_a: assert property ($rose(pfm_rd_o) |-> pfm_seq)
    else $error("flash read answer wrong");
  core_latency_a: assert property (file_rd_i && !busy_o && file_addr_i inside {[7'h02:7'h0b]}
    |=> rd_valid_o) else $error("core register read late");
  flag_sticky_a: assert property (stack_overflow_flag_o && !stack_flag_clr_i[0]
    |=> stack_overflow_flag_o) else $error("overflow flag lost");
  soft_cause_a: assert property (soft_reset_o |-> stack_overflow_flag_o || stack_underflow_flag_o)
    else $error("soft reset without stack fault");
endmodule
`default_nettype wire

// ===== cmam_mem_model.sv
/*
  Flash array and banked data RAM facing the core memory map block.
  Assumes one core clock; the flash answers a held address next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cmam_mem_model (
  input  wire logic        clk_i,       // Core clock
  input  wire logic [14:0] pfm_addr_i,  // Flash address
  output logic      [13:0] pfm_data_o,  // Flash word
  input  wire logic [11:0] ram_addr_i,  // Data address
  input  wire logic        ram_re_i,    // Read strobe
  input  wire logic        ram_we_i,    // Write strobe
  input  wire logic [7:0]  ram_wdata_i, // Write data
  output logic      [7:0]  ram_rdata_o  // Read data
);
  logic [7:0] ram [4096];
  function automatic logic [13:0] pf(input logic [14:0] a);
    return a[13:0] ^ 14'h2a5c;
  endfunction
  initial begin
    ram_rdata_o = 8'h00;
    foreach (ram[i]) ram[i] = 8'(i);
  end
  // Idle read data toggles so a late capture cannot pass by luck
  always @(posedge clk_i) begin
    pfm_data_o <= pf(pfm_addr_i);
    if (ram_we_i) ram[ram_addr_i] <= ram_wdata_i;
    ram_rdata_o <= ram_re_i ? ram[ram_addr_i] : ~ram_rdata_o;
  end
endmodule
`default_nettype wire

// ===== cmam_pkg.sv
/*
  Types of the core memory map block: sequencer states, data reference
  and the packed state record of the top module.
  Assumes cmam_cfg.svh is reachable by bare name.
*/
`include "cmam_cfg.svh"

package cmam_pkg;

  typedef enum logic [2:0] {
    CMAM_IDLE     = 3'b000,
    CMAM_RAM_WAIT = 3'b001,
    CMAM_RAM_CAP  = 3'b010,
    CMAM_PFM_WAIT = 3'b011,
    CMAM_PFM_XTRA = 3'b100,
    CMAM_PFM_CAP  = 3'b101
  } cmam_state_e;

  typedef struct packed {
    logic        hit;
    logic        core;
    logic [11:0] addr;
  } cmam_dref_s;

  typedef struct packed {
    cmam_state_e                          st;
    logic [14:0]                          pc;
    logic [6:0]                           latch_high;
    logic [4:0]                           flags;
    logic [4:0]                           bank_select;
    logic [7:0]                           working_register;
    logic [7:0]                           interrupt_control;
    logic [15:0]                          ptr0;
    logic [15:0]                          ptr1;
    logic [7:0]                           sh_working_register;
    logic [4:0]                           sh_flags;
    logic [4:0]                           sh_bsr;
    logic [6:0]                           sh_latch;
    logic [15:0]                          sh_ptr0;
    logic [15:0]                          sh_ptr1;
    logic [`CMAM_STACK_DEPTH-1:0][14:0]   stack;
    logic [4:0]                           sp;
    logic                                 ovf;
    logic                                 unf;
    logic                                 soft_rst;
    logic [14:0]                          pfm_addr;
    logic                                 pfm_rd;
    logic                                 hef;
    logic [11:0]                          ram_addr;
    logic                                 ram_re;
    logic                                 ram_we;
    logic [7:0]                           ram_wdata;
    logic                                 rd_valid;
    logic [7:0]                           rd_data;
    logic                                 busy;
  } cmam_regs_s;

endpackage

// ===== tb_top.sv
/*
  Testbench of the core memory map block: register port tasks and tests.
  Assumes cmam_core, cmam_mem_model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int         PW = 1024;
  localparam logic [4:0] FE = 5'h01, RE = 5'h02, CA = 5'h04, RF = 5'h08, IQ = 5'h10;
  logic        clk_i, srst_i, fetch_i, call_i, ret_i, irq_i, retfie_i, sr_seen;
  logic        stack_reset_en_i, file_rd_i, file_wr_i, rd_valid_o, busy_o;
  logic        pfm_rd_o, hef_region_o, ram_re_o, ram_we_o, soft_reset_o;
  logic        stack_overflow_flag_o, stack_underflow_flag_o;
  logic [1:0]  stack_flag_clr_i;
  logic [6:0]  file_addr_i;
  logic [7:0]  file_wdata_i, rd_data_o, ram_wdata_o, ram_rdata_i;
  logic [11:0] ram_addr_o;
  logic [13:0] pfm_data_i, w;
  logic [14:0] target_i, pc_o, pfm_addr_o;
  int          err_total = 0, checked = 0, we_cnt = 0, cyc = 0, weq;

  cmam_core #(.PROG_WORDS(PW), .GPR_BANKS(2)) cmam_core_i (.*);
  cmam_mem_model cmam_mem_model_i (
    .clk_i      (clk_i),
    .pfm_addr_i (pfm_addr_o),
    .pfm_data_o (pfm_data_i),
    .ram_addr_i (ram_addr_o),
    .ram_re_i   (ram_re_o),
    .ram_we_i   (ram_we_o),
    .ram_wdata_i(ram_wdata_o),
    .ram_rdata_o(ram_rdata_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Cycle ceiling well above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (ram_we_o) we_cnt++;
    if (soft_reset_o) sr_seen = 1'b1;
    else if (srst_i) sr_seen = 1'b0;
    if (cyc == 4000) begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    file_wr_i = 1'b1;
    file_addr_i = a;
    file_wdata_i = d;
    @(negedge clk_i);
    file_wr_i = 1'b0;
  endtask
  // Waits a bounded time for the answer, then compares its byte
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    int n;
    @(negedge clk_i);
    file_rd_i = 1'b1;
    file_addr_i = a;
    @(negedge clk_i);
    file_rd_i = 1'b0;
    n = 0;
    while (rd_valid_o !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    chk({8'h00, rd_data_o}, {8'h00, exp});
  endtask
  task automatic op(input logic [4:0] v, input logic [14:0] t);
    @(negedge clk_i);
    {irq_i, retfie_i, call_i, ret_i, fetch_i} = v;
    target_i = t;
    @(negedge clk_i);
    {irq_i, retfie_i, call_i, ret_i, fetch_i} = 5'h00;
  endtask

  initial begin
    srst_i = 1'b1;
    {irq_i, retfie_i, call_i, ret_i, fetch_i} = 5'h00;
    {file_rd_i, file_wr_i} = 2'h0;
    {file_addr_i, file_wdata_i, target_i} = 30'h0;
    stack_reset_en_i = 1'b1;
    stack_flag_clr_i = 2'h0;
    repeat (6) @(negedge clk_i);
    srst_i = 1'b0;
    chk({1'b0, pc_o}, 16'h0000);
    rdc(7'h03, 8'h18);
    $display("test reset done");
    wr(7'h08, 8'h05);
    wr(7'h09, 8'ha5);
    rdc(7'h09, 8'ha5);
    rdc(7'h08, 8'h05);
    wr(7'h08, 8'h00);
    rdc(7'h09, 8'ha5);
    wr(7'h70, 8'h5e);
    wr(7'h08, 8'h01);
    wr(7'h20, 8'h3c);
    rdc(7'h20, 8'h3c);
    chk({8'h00, cmam_mem_model_i.ram[12'h0a0]}, 16'h003c);
    rdc(7'h70, 8'h5e);
    wr(7'h08, 8'h05);
    rdc(7'h20, 8'h00);
    rdc(7'h0c, 8'h8c);
    rdc(7'h70, 8'h5e);
    $display("test banks done");
    wr(7'h04, 8'h55);
    wr(7'h05, 8'h20);
    wr(7'h00, 8'h77);
    rdc(7'h00, 8'h77);
    chk({8'h00, cmam_mem_model_i.ram[12'h0a5]}, 16'h0077);
    wr(7'h04, 8'ha0);
    wr(7'h05, 8'h00);
    rdc(7'h00, 8'h3c);
    wr(7'h06, 8'h05);
    wr(7'h07, 8'h84);
    w = cmam_mem_model_i.pf(15'h0005);
    rdc(7'h01, w[7:0]);
    weq = we_cnt;
    wr(7'h01, 8'hff);
    chk(16'(we_cnt), 16'(weq));
    rdc(7'h01, w[7:0]);
    rdc(7'h07, 8'h84);
    $display("test pointers done");
    repeat (3) op(FE, 15'h0000);
    chk({1'b0, pc_o}, 16'h0003);
    wr(7'h0a, 8'h07);
    wr(7'h02, 8'hfe);
    @(negedge clk_i);
    chk({1'b0, pc_o}, 16'h03fe);
    chk({15'h0, hef_region_o}, 16'h0001);
    repeat (3) op(FE, 15'h0000);
    chk({1'b0, pc_o}, 16'h0001);
    wr(7'h09, 8'h11);
    op(IQ, 15'h0000);
    chk({1'b0, pc_o}, 16'h0004);
    wr(7'h09, 8'h22);
    op(RF, 15'h0000);
    chk({1'b0, pc_o}, 16'h0001);
    rdc(7'h09, 8'h11);
    $display("test counter done");
    for (int i = 1; i <= 17; i++) op(CA, 15'(15'h100 + i));
    chk({14'h0, stack_overflow_flag_o, soft_reset_o}, 16'h0003);
    for (int i = 15; i >= 1; i--) begin
      op(RE, 15'h0000);
      chk({1'b0, pc_o}, 16'(16'h100 + i));
    end
    op(RE, 15'h0000);
    chk({1'b0, pc_o}, 16'h0001);
    stack_reset_en_i = 1'b0;
    op(RE, 15'h0000);
    chk({1'b0, pc_o}, 16'h0001);
    chk({14'h0, stack_underflow_flag_o, soft_reset_o}, 16'h0002);
    @(negedge clk_i);
    stack_flag_clr_i = 2'h3;
    @(negedge clk_i);
    stack_flag_clr_i = 2'h0;
    @(negedge clk_i);
    chk({14'h0, stack_underflow_flag_o, stack_overflow_flag_o}, 16'h0000);
    chk({15'h0, sr_seen}, 16'h0001);
    $display("test stack done");
    summarize();
  end
endmodule
bind cmam_core cmam_core_properties #(.PROG_WORDS(PROG_WORDS)) cmam_core_properties_i (.*);
`default_nettype wire
